// [iwd_watchdog.sv]
// Purpose: Free-running watchdog with key commands, window check and AXI4-Lite registers.
// Assumes: CORE_CLK is the watchdog's own oscillator, not the system clock.
// Notes: The system reset request is held until RSTN.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module iwd_watchdog
	import iwd_pkg::*;
#(
	parameter int UPD_CYCLES = UPDATE_CYCLES
)
(
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic HW_START_STRAP,
	input wire logic DEBUG_HALT,
	input wire logic DEBUG_FREEZE_CONTROL,
	output logic WDG_RESET_REQ,
	output logic WDG_RUNNING
);
	// ----------------------------------------
	// Sub-blocks
	// ----------------------------------------
	iwd_core_if core ();

	iwd_prescaler u_presc (
		.clk(CORE_CLK),
		.rst_n(RSTN),
		.bus(core)
	);

	iwd_update_tracker #(.CYCLES(UPD_CYCLES)) u_track (
		.clk(CORE_CLK),
		.rst_n(RSTN),
		.bus(core)
	);

	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	function automatic iwd_sel_type decode(input logic [ADDR_W-1:0] a);
		if (a == OFF_COMMAND_KEY)
			decode = SEL_KEY;
		else if (a == OFF_CLOCK_DIVIDER_SELECT)
			decode = SEL_DIV;
		else if (a == OFF_COUNTER_RELOAD_VALUE)
			decode = SEL_RLD;
		else if (a == OFF_UPDATE_PENDING_FLAGS)
			decode = SEL_STS;
		else if (a == OFF_REFRESH_WINDOW_LIMIT)
			decode = SEL_WIN;
		else
			decode = SEL_NONE;
	endfunction : decode

	function automatic logic [CNT_W-1:0] merge12(input logic [CNT_W-1:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge12 = {s[1] ? d[11:8] : old[11:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge12

	// ----------------------------------------
	// Pin synchronisers and strap capture
	// ----------------------------------------
	logic [2:0] sync1_reg, sync2_reg;
	logic [1:0] boot_reg, boot_next;
	logic freeze, hw_boot_start;

	always_comb begin
		boot_next = (boot_reg == STRAP_SETTLE + 2'h1) ? boot_reg : boot_reg + 2'h1;
		hw_boot_start = (boot_reg == STRAP_SETTLE) && sync2_reg[0];
		freeze = sync2_reg[1] && sync2_reg[2];
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			boot_reg <= '0;
		end else begin
			sync1_reg <= {DEBUG_FREEZE_CONTROL, DEBUG_HALT, HW_START_STRAP};
			sync2_reg <= sync1_reg;
			boot_reg <= boot_next;
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
	logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic do_write;
	iwd_sel_type wsel, rsel;

	// Configuration and counting state
	logic [DIV_SEL_W-1:0] div_reg, div_next, div_act_reg, div_act_next;
	logic [CNT_W-1:0] rld_reg, rld_next, rld_act_reg, rld_act_next;
	logic [CNT_W-1:0] win_reg, win_next, win_act_reg, win_act_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic unlocked_reg, unlocked_next, run_reg, run_next, rst_reg, rst_next;
	logic key_any, key_full, refresh, start_cmd, div_wr, rld_wr, win_wr, restart;

	always_comb begin
		aw_hold_next = aw_hold_reg;
		aw_addr_next = aw_addr_reg;
		w_hold_next = w_hold_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (S_AXI_AWVALID && awready_reg) begin
			aw_hold_next = 1'b1;
			aw_addr_next = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && wready_reg) begin
			w_hold_next = 1'b1;
			w_data_next = S_AXI_WDATA;
			w_strb_next = S_AXI_WSTRB;
		end
		if (bvalid_reg && S_AXI_BREADY)
			bvalid_next = 1'b0;
		do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
		wsel = decode(aw_addr_reg);
		if (do_write) begin
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (wsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
		end
		awready_next = !aw_hold_next && !bvalid_next;
		wready_next = !w_hold_next && !bvalid_next;

		arready_next = arready_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		rsel = decode(S_AXI_ARADDR);
		if (rvalid_reg && S_AXI_RREADY) begin
			rvalid_next = 1'b0;
			arready_next = 1'b1;
		end
		if (S_AXI_ARVALID && arready_reg) begin
			arready_next = 1'b0;
			rvalid_next = 1'b1;
			rresp_next = (rsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
			rdata_next = '0; // Key, unmapped and reserved bits read zero
			if (rsel == SEL_DIV)
				rdata_next[DIV_SEL_W-1:0] = div_reg;
			else if (rsel == SEL_RLD)
				rdata_next[CNT_W-1:0] = rld_reg;
			else if (rsel == SEL_STS)
				rdata_next[NUM_FLAGS-1:0] = core.pending;
			else if (rsel == SEL_WIN)
				rdata_next[CNT_W-1:0] = win_reg;
		end
	end

	// ----------------------------------------
	// Key commands and protected registers
	// ----------------------------------------
	always_comb begin
		key_any = do_write && (wsel == SEL_KEY);
		key_full = key_any && (w_strb_reg[1:0] == 2'b11);
		refresh = key_full && (w_data_reg[15:0] == KEY_REFRESH);
		start_cmd = key_full && (w_data_reg[15:0] == KEY_START);
		unlocked_next = unlocked_reg;
		if (key_any)
			unlocked_next = key_full && (w_data_reg[15:0] == KEY_UNLOCK);
		// Writes while locked or still settling are dropped silently
		div_wr = do_write && (wsel == SEL_DIV) && unlocked_reg && w_strb_reg[0]
			&& !core.pending[FLAG_DIVIDER];
		rld_wr = do_write && (wsel == SEL_RLD) && unlocked_reg && (w_strb_reg[1:0] != 2'b00)
			&& !core.pending[FLAG_RELOAD];
		win_wr = do_write && (wsel == SEL_WIN) && unlocked_reg && (w_strb_reg[1:0] != 2'b00)
			&& !core.pending[FLAG_WINDOW];
		div_next = div_wr ? w_data_reg[DIV_SEL_W-1:0] : div_reg;
		rld_next = rld_wr ? merge12(rld_reg, w_data_reg, w_strb_reg) : rld_reg;
		win_next = win_wr ? merge12(win_reg, w_data_reg, w_strb_reg) : win_reg;
		core.set = {win_wr, rld_wr, div_wr};
		// New values reach the counting side only once their flag drops
		div_act_next = core.done[FLAG_DIVIDER] ? div_reg : div_act_reg;
		rld_act_next = core.done[FLAG_RELOAD] ? rld_reg : rld_act_reg;
		win_act_next = core.done[FLAG_WINDOW] ? win_reg : win_act_reg;
	end

	// ----------------------------------------
	// Down-counter and reset request
	// ----------------------------------------
	always_comb begin
		cnt_next = cnt_reg;
		run_next = run_reg;
		rst_next = rst_reg;
		restart = 1'b0;
		if ((start_cmd || hw_boot_start) && !run_reg) begin
			run_next = 1'b1;
			cnt_next = CNT_START;
			restart = 1'b1;
		end else if (refresh && run_reg && (win_act_reg != WINDOW_RESET) && (cnt_reg > win_act_reg)) begin
			rst_next = 1'b1;
		end else if (refresh || core.done[FLAG_WINDOW]) begin
			cnt_next = core.done[FLAG_RELOAD] ? rld_reg : rld_act_reg;
			restart = 1'b1;
		end else if (run_reg && (cnt_reg == CNT_ZERO)) begin
			rst_next = 1'b1;
		end else if (run_reg && core.tick) begin
			cnt_next = cnt_reg - 1'b1;
		end
		core.restart = restart;
		core.run = run_reg && !freeze;
		core.div_sel = div_act_reg;
	end

	// No sleep input exists: only CORE_CLK and the debug freeze gate counting, so low-power modes do not stop it
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_hold_reg <= 1'b0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
			div_reg <= DIV_SEL_RESET;
			div_act_reg <= DIV_SEL_RESET;
			rld_reg <= RELOAD_RESET;
			rld_act_reg <= RELOAD_RESET;
			win_reg <= WINDOW_RESET;
			win_act_reg <= WINDOW_RESET;
			cnt_reg <= CNT_START;
			unlocked_reg <= 1'b0;
			run_reg <= 1'b0;
			rst_reg <= 1'b0;
		end else begin
			aw_hold_reg <= aw_hold_next;
			aw_addr_reg <= aw_addr_next;
			w_hold_reg <= w_hold_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next || (!rvalid_next && !arready_reg && !rvalid_reg);
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			div_reg <= div_next;
			div_act_reg <= div_act_next;
			rld_reg <= rld_next;
			rld_act_reg <= rld_act_next;
			win_reg <= win_next;
			win_act_reg <= win_act_next;
			cnt_reg <= cnt_next;
			unlocked_reg <= unlocked_next;
			run_reg <= run_next;
			rst_reg <= rst_next;
		end
	end

	assign S_AXI_AWREADY = awready_reg;
	assign S_AXI_WREADY = wready_reg;
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_reg;
	assign S_AXI_ARREADY = arready_reg;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_reg;
	assign WDG_RESET_REQ = rst_reg;
	assign WDG_RUNNING = run_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	localparam int FLAG_BOUND = 9;

	if (UPD_CYCLES < 1 || UPD_CYCLES > 8) begin : g_bad_cycles
		$error("UPD_CYCLES must lie in 1..8");
	end

	a_start_runs: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		start_cmd && !run_reg |=> run_reg && (cnt_reg == CNT_START))
		else $error("start code did not start the count");
	a_expiry_reset: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		run_reg && (cnt_reg == CNT_ZERO) && !refresh |=> WDG_RESET_REQ)
		else $error("expired counter gave no reset");
	a_refresh_load: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		refresh && run_reg && (win_act_reg == WINDOW_RESET) && !core.done[FLAG_RELOAD]
		|=> cnt_reg == $past(rld_act_reg))
		else $error("refresh did not load the reload value");
	a_unlock_opens: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		key_full && (w_data_reg[15:0] == KEY_UNLOCK) |=> unlocked_reg)
		else $error("unlock code left registers locked");
	a_other_locks: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		key_any && (w_data_reg[15:0] != KEY_UNLOCK) |=> !unlocked_reg)
		else $error("key write did not relock");
	a_refresh_locks: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		refresh ##1 !key_any |-> !unlocked_reg)
		else $error("refresh left registers unlocked");
	a_window_early: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		refresh && run_reg && (win_act_reg != WINDOW_RESET) && (cnt_reg > win_act_reg)
		|=> WDG_RESET_REQ && $stable(cnt_reg))
		else $error("early refresh was not punished");
	a_window_reload: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		$rose(core.pending[FLAG_WINDOW]) |-> ##[1:FLAG_BOUND] (cnt_reg == rld_act_reg))
		else $error("window write did not reload the counter");
	a_locked_drop: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		do_write && (wsel == SEL_DIV) && !unlocked_reg |=> $stable(div_reg))
		else $error("locked divider write took effect");
	a_flag_clears: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		$rose(core.pending[FLAG_RELOAD]) |-> ##[1:FLAG_BOUND] !core.pending[FLAG_RELOAD])
		else $error("reload flag stuck");
	a_freeze_holds: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		freeze && !restart ##1 freeze && !restart && !core.done[FLAG_WINDOW] && !refresh
		|=> $stable(cnt_reg))
		else $error("counter moved while frozen");
endmodule : iwd_watchdog
`default_nettype wire

// [iwd_pkg.sv]
// Purpose: Shared constants and types of the free-running watchdog.
// Assumes: Register bus is AXI4-Lite with 32-bit data.
// Notes: All offsets are byte addresses.
package iwd_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFF_COMMAND_KEY = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_CLOCK_DIVIDER_SELECT = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_COUNTER_RELOAD_VALUE = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_UPDATE_PENDING_FLAGS = 5'h0c;
	localparam logic [ADDR_W-1:0] OFF_REFRESH_WINDOW_LIMIT = 5'h10;

	// ----------------------------------------
	// Command codes and field layout
	// ----------------------------------------
	localparam logic [15:0] KEY_START = 16'hcccc;
	localparam logic [15:0] KEY_REFRESH = 16'haaaa;
	localparam logic [15:0] KEY_UNLOCK = 16'h5555;
	localparam int CNT_W = 12;
	localparam int DIV_SEL_W = 3;
	localparam int PRESC_W = 8;
	localparam logic [CNT_W-1:0] CNT_START = 12'hfff;
	localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
	localparam logic [CNT_W-1:0] RELOAD_RESET = 12'hfff;
	localparam logic [CNT_W-1:0] WINDOW_RESET = 12'hfff;
	localparam logic [DIV_SEL_W-1:0] DIV_SEL_RESET = 3'h0;
	localparam int DIV_BASE_LOG2 = 2;
	localparam int NUM_FLAGS = 3;
	localparam int FLAG_DIVIDER = 0;
	localparam int FLAG_RELOAD = 1;
	localparam int FLAG_WINDOW = 2;

	// ----------------------------------------
	// Timing, bus responses and register selects
	// ----------------------------------------
	localparam int UPDATE_CYCLES = 4;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {
		SEL_KEY = 3'b000,
		SEL_DIV = 3'b001,
		SEL_RLD = 3'b010,
		SEL_STS = 3'b011,
		SEL_WIN = 3'b100,
		SEL_NONE = 3'b111
	} iwd_sel_type;

endpackage : iwd_pkg

// [iwd_core_if.sv]
// Purpose: Carrier between the watchdog core, its prescaler and its update tracker.
// Assumes: One clock for all three modules.
// Notes: Prescaler and tracker each drive only their own outputs.
`timescale 1ns/10ps
`default_nettype none
interface iwd_core_if;
	import iwd_pkg::*;
	logic [DIV_SEL_W-1:0] div_sel;
	logic run;
	logic restart;
	logic tick;
	logic [NUM_FLAGS-1:0] set;
	logic [NUM_FLAGS-1:0] pending;
	logic [NUM_FLAGS-1:0] done;
	modport core (output div_sel, output run, output restart, input tick,
		output set, input pending, input done);
	modport presc (input div_sel, input run, input restart, output tick);
	modport flags (input set, output pending, output done);
endinterface : iwd_core_if
`default_nettype wire

// [iwd_prescaler.sv]
// Purpose: Divides the watchdog clock by 4 << code, saturating at 256.
// Assumes: Code is stable between restarts.
// Notes: Tick is a one-cycle pulse taken from a register.
`timescale 1ns/10ps
`default_nettype none
module iwd_prescaler
	import iwd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	iwd_core_if.presc bus
);
	logic [PRESC_W-1:0] count_reg, count_next;
	logic tick_reg, tick_next;

	function automatic logic [PRESC_W-1:0] div_limit(input logic [DIV_SEL_W-1:0] code);
		int shift;
		shift = DIV_BASE_LOG2 + int'(code);
		if (shift > PRESC_W)
			shift = PRESC_W;
		div_limit = PRESC_W'((1 << shift) - 1);
	endfunction : div_limit

	always_comb begin
		count_next = count_reg;
		tick_next = 1'b0;
		if (bus.restart) begin
			count_next = '0;
		end else if (bus.run) begin
			if (count_reg >= div_limit(bus.div_sel)) begin
				count_next = '0;
				tick_next = 1'b1;
			end else begin
				count_next = count_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			tick_reg <= tick_next;
		end
	end

	assign bus.tick = tick_reg;
endmodule : iwd_prescaler
`default_nettype wire

// [iwd_update_tracker.sv]
// Purpose: Holds one busy flag per protected register while its update settles.
// Assumes: A set only arrives while the flag is clear.
// Notes: Done pulses for one cycle as the flag drops.
`timescale 1ns/10ps
`default_nettype none
module iwd_update_tracker
	import iwd_pkg::*;
#(
	parameter int CYCLES = UPDATE_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_n,
	iwd_core_if.flags bus
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_reg [NUM_FLAGS];
	logic [CW-1:0] cnt_next [NUM_FLAGS];
	logic [NUM_FLAGS-1:0] pend_w, done_w;

	if (CYCLES < 1) begin : g_bad_cycles
		$error("CYCLES must be at least one");
	end

	always_comb begin
		for (int i = 0; i < NUM_FLAGS; i++) begin
			cnt_next[i] = cnt_reg[i];
			pend_w[i] = (cnt_reg[i] != '0);
			done_w[i] = (cnt_reg[i] == CW'(1));
			if (bus.set[i] && !pend_w[i])
				cnt_next[i] = CW'(CYCLES);
			else if (pend_w[i])
				cnt_next[i] = cnt_reg[i] - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < NUM_FLAGS; i++) begin
			if (!rst_n)
				cnt_reg[i] <= '0;
			else
				cnt_reg[i] <= cnt_next[i];
		end
	end

	assign bus.pending = pend_w;
	assign bus.done = done_w;
endmodule : iwd_update_tracker
`default_nettype wire

// [iwd_testbench.sv]
// Purpose: Self-checking bench of the free-running watchdog.
// Assumes: Settling of protected writes lengthened to 8 cycles so pending flags can be seen.
// Notes: Timeouts are judged with a few cycles of slack for the sync stages.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import iwd_pkg::*;
	localparam logic [31:0] K_START = {16'h0, KEY_START};
	localparam logic [31:0] K_REFRESH = {16'h0, KEY_REFRESH};
	localparam logic [31:0] K_UNLOCK = {16'h0, KEY_UNLOCK};
	logic CORE_CLK = 1'b0, RSTN = 1'b0;
	logic [ADDR_W-1:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
	logic [31:0] S_AXI_WDATA = '0;
	logic [3:0] S_AXI_WSTRB = '0;
	logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
	logic HW_START_STRAP = 1'b0, DEBUG_HALT = 1'b0, DEBUG_FREEZE_CONTROL = 1'b0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, WDG_RESET_REQ, WDG_RUNNING;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic [31:0] S_AXI_RDATA, v;
	int fail_count = 0, compares = 0, cyc = 0, t0, k, rnd;
	int div_m, rld_m, win_m;
	bit unlk;

	always #25 CORE_CLK = ~CORE_CLK;
	always @(posedge CORE_CLK) cyc <= cyc + 1;

	iwd_watchdog #(.UPD_CYCLES(8)) DUT (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
		.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
		.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .HW_START_STRAP(HW_START_STRAP),
		.DEBUG_HALT(DEBUG_HALT), .DEBUG_FREEZE_CONTROL(DEBUG_FREEZE_CONTROL),
		.WDG_RESET_REQ(WDG_RESET_REQ), .WDG_RUNNING(WDG_RUNNING));

	// ----------------------------------------
	// Model and comparison
	// ----------------------------------------
	function automatic logic [31:0] exp_rd(input logic [ADDR_W-1:0] a);
		case (a)
			OFF_CLOCK_DIVIDER_SELECT: return div_m;
			OFF_COUNTER_RELOAD_VALUE: return rld_m;
			OFF_REFRESH_WINDOW_LIMIT: return win_m;
			default: return 32'h0;
		endcase
	endfunction : exp_rd

	function automatic logic [1:0] exp_rsp(input logic [ADDR_W-1:0] a);
		return (a > OFF_REFRESH_WINDOW_LIMIT) ? RESP_DECERR : RESP_OKAY;
	endfunction : exp_rsp

	task automatic finish_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	task automatic hang();
		fail_count++;
		$display("CHECK FAILED wait expected answer seen timeout");
		finish_test();
	endtask : hang

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Sync stages and poll granularity blur the moment by a few cycles
	task automatic chk_t(input string nm, input int e, input int g);
		compares++;
		if (g < e - 6 || g > e + 6) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk_t

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge CORE_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_WSTRB <= s;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge CORE_CLK);
			if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
			if (S_AXI_BVALID === 1'b1) break;
		end
		if (n == 40) hang();
		S_AXI_BREADY <= 1'b0;
		chk("bresp", {30'h0, exp_rsp(a)}, {30'h0, S_AXI_BRESP});
		if (a == OFF_COMMAND_KEY) unlk = d[15:0] == KEY_UNLOCK && s[1:0] == 2'b11;
		else if (unlk && a == OFF_CLOCK_DIVIDER_SELECT) div_m = d[2:0];
		else if (unlk && a == OFF_COUNTER_RELOAD_VALUE) rld_m = d[11:0];
		else if (unlk && a == OFF_REFRESH_WINDOW_LIMIT) win_m = d[11:0];
	endtask : wr

	task automatic rdx(input logic [ADDR_W-1:0] a, output logic [1:0] r);
		int n;
		@(posedge CORE_CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge CORE_CLK);
			if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
			if (S_AXI_RVALID === 1'b1) break;
		end
		if (n == 40) hang();
		v = S_AXI_RDATA;
		r = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
	endtask : rdx

	task automatic rd(input string nm, input logic [ADDR_W-1:0] a);
		logic [1:0] r;
		rdx(a, r);
		chk(nm, exp_rd(a), v);
		chk("rresp", {30'h0, exp_rsp(a)}, {30'h0, r});
	endtask : rd

	task automatic flag(input logic [31:0] e);
		logic [1:0] r;
		rdx(OFF_UPDATE_PENDING_FLAGS, r);
		chk("flags", e, v);
	endtask : flag

	task automatic wait_idle();
		logic [1:0] r;
		int n;
		for (n = 0; n < 20; n++) begin
			rdx(OFF_UPDATE_PENDING_FLAGS, r);
			if (v === 32'h0) break;
		end
		if (n == 20) hang();
	endtask : wait_idle

	task automatic wait_req(input int t, input int e);
		int n;
		for (n = 0; n < 20000; n++) begin
			if (WDG_RESET_REQ === 1'b1) break;
			@(posedge CORE_CLK);
		end
		if (n == 20000) hang();
		chk_t("timeout", e, cyc - t);
	endtask : wait_req

	task automatic do_reset(input logic strap);
		RSTN <= 1'b0;
		HW_START_STRAP <= strap;
		repeat (16) @(posedge CORE_CLK);
		RSTN <= 1'b1;
		div_m = DIV_SEL_RESET;
		rld_m = RELOAD_RESET;
		win_m = WINDOW_RESET;
		unlk = 0;
		@(posedge CORE_CLK);
	endtask : do_reset

	task automatic setup(input logic [31:0] dv, input logic [31:0] rl);
		wr(OFF_COMMAND_KEY, K_START, 4'hf);
		wr(OFF_COMMAND_KEY, K_UNLOCK, 4'hf);
		wr(OFF_CLOCK_DIVIDER_SELECT, dv, 4'hf);
		flag(32'h1);
		wait_idle();
		wr(OFF_COUNTER_RELOAD_VALUE, rl, 4'hf);
		flag(32'h2);
		wait_idle();
		rd("divider", OFF_CLOCK_DIVIDER_SELECT);
	endtask : setup

	// A window write reloads the counter as its flag drops, so it also sets the timeout origin
	task automatic set_win(input logic [31:0] wn);
		wr(OFF_REFRESH_WINDOW_LIMIT, wn, 4'hf);
		flag(32'h4);
		wait_idle();
	endtask : set_win

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(15));
		do_reset(1'b0);
		chk("running", 32'h0, {31'h0, WDG_RUNNING});
		rd("key", OFF_COMMAND_KEY);
		rd("divider", OFF_CLOCK_DIVIDER_SELECT);
		rd("reload", OFF_COUNTER_RELOAD_VALUE);
		rd("flags", OFF_UPDATE_PENDING_FLAGS);
		rd("window", OFF_REFRESH_WINDOW_LIMIT);
		rd("unmapped", 5'h14);
		wr(OFF_COUNTER_RELOAD_VALUE, 32'h123, 4'hf);
		wr(OFF_COMMAND_KEY, K_UNLOCK, 4'h1);
		wr(OFF_COUNTER_RELOAD_VALUE, 32'h234, 4'hf);
		wr(OFF_COMMAND_KEY, K_UNLOCK, 4'hf);
		wr(OFF_COMMAND_KEY, 32'h1234, 4'hf);
		wr(OFF_COUNTER_RELOAD_VALUE, 32'h345, 4'hf);
		rd("locked", OFF_COUNTER_RELOAD_VALUE);
		// Halt without freeze must leave the count running
		DEBUG_HALT <= 1'b1;
		wr(OFF_COMMAND_KEY, K_START, 4'hf);
		t0 = cyc;
		chk("running", 32'h1, {31'h0, WDG_RUNNING});
		wait_req(t0, CNT_START * 4);
		for (k = 0; k < 8; k++) begin
			do_reset(1'b0);
			rnd = 2 + $urandom % 4;
			setup(k, rnd);
			rd("window", OFF_REFRESH_WINDOW_LIMIT);
			wr(OFF_COMMAND_KEY, K_REFRESH, 4'hf);
			t0 = cyc;
			wr(OFF_COUNTER_RELOAD_VALUE, 32'h7, 4'hf);
			rd("relocked", OFF_COUNTER_RELOAD_VALUE);
			wait_req(t0, rnd * (k > 5 ? 256 : 4 << k));
		end
		do_reset(1'b0);
		setup(0, 32'h800);
		set_win(32'h100);
		t0 = cyc;
		rd("window", OFF_REFRESH_WINDOW_LIMIT);
		wait_req(t0, 32'h800 * 4);
		do_reset(1'b0);
		setup(0, 32'h40);
		set_win(32'h20);
		t0 = cyc;
		wr(OFF_COMMAND_KEY, K_REFRESH, 4'hf);
		wait_req(t0, 4);
		do_reset(1'b0);
		setup(0, 32'h10);
		// Freeze first so that the short reload below can only expire once released
		DEBUG_FREEZE_CONTROL <= 1'b1;
		repeat (4) @(posedge CORE_CLK);
		wr(OFF_COMMAND_KEY, K_REFRESH, 4'hf);
		repeat (300) @(posedge CORE_CLK);
		chk("frozen", 32'h0, {31'h0, WDG_RESET_REQ});
		DEBUG_FREEZE_CONTROL <= 1'b0;
		t0 = cyc;
		wait_req(t0, 32'h10 * 4);
		do_reset(1'b1);
		repeat (6) @(posedge CORE_CLK);
		chk("strap_run", 32'h1, {31'h0, WDG_RUNNING});
		finish_test();
	end
endmodule : testbench
`default_nettype wire
